/* File: src/dair_router.sv */
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Paired mode: primary transmit carries left.
// R2: Paired mode: right channel from secondary receive.
// R3: Single mode: ignore secondary receive port.
// R4: Secondary transmit copies primary, or second channel.
// R5: Coax receiver takes 24-bit, ignores status bits.
// R6: Coax/AES clock only unless selected output.
// R7: Optical clock only unless selected output.
// R8: Four identical word clocks, aligned to reference.
// R9: Word clock input one or two selected.
// R10: Converter samples 24-bit, six rates, all outputs.
// R11: Coax transmitter carries 24-bit up to 192k.
// R12: Single link at 44.1, 48, 96 kHz.
// R13: Paired link above 96 kHz per selection.
// R14: Optical interleave: four channels, then eight.
// R15: Converter monitor feeds converter samples to DAC.
// R16: Setting change briefly mutes the stream.
// R17: External reference may be multiple or submultiple.
// R18: Five external timing references accepted.
// R19: Conversion runs only while locked.
// R20: Lock indication when synchronised externally.
// R21: Selector picks coax when set, else AES.
// R22: Link mode selects paired; coax unaffected (here coax right carries left while paired, as coax mirrors primary).
// R23: Coax transmitter mirrors primary AES stream.
// R24: Internal always locked; external needs clock present.
// R25: Silence on all paths while unlocked.
module dair_router #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // APB slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Reference pins: word 1, word 2, AES frame, coax frame, optical frame
  input  wire logic [4:0]        ref_pin,
  // Receivers, decoded on clk
  input  wire logic              aes_a_rx_valid,
  input  wire logic [W-1:0]      aes_a_rx_left,
  input  wire logic [W-1:0]      aes_a_rx_right,
  input  wire logic              aes_b_rx_valid,
  input  wire logic [W-1:0]      aes_b_rx_right,
  input  wire logic              spdif_rx_valid,
  input  wire logic [W-1:0]      spdif_rx_left,
  input  wire logic [W-1:0]      spdif_rx_right,
  input  wire logic              opt_rx_valid,
  input  wire logic [8*W-1:0]    opt_rx_data,
  // Converter core
  input  wire logic              adc_valid,
  input  wire logic [W-1:0]      adc_left,
  input  wire logic [W-1:0]      adc_right,
  output logic                   adc_run,
  output logic      [W-1:0]      dac_left,
  output logic      [W-1:0]      dac_right,
  output logic                   sample_tick,
  // Transmitters
  output logic      [W-1:0]      aes_a_tx_left,
  output logic      [W-1:0]      aes_a_tx_right,
  output logic      [W-1:0]      aes_b_tx_left,
  output logic      [W-1:0]      aes_b_tx_right,
  output logic      [W-1:0]      spdif_tx_left,
  output logic      [W-1:0]      spdif_tx_right,
  output logic      [8*W-1:0]    opt_tx_data,
  // Clocking
  output logic      [3:0]        word_clk_out,
  output logic                   locked
);
  localparam logic [12:0] TIMEOUT = 13'(dair_pkg::LOCK_TIMEOUT_CYC);
  localparam logic [7:0]  SETTLE  = 8'(dair_pkg::SETTLE_CYC);

  logic [31:0]  ctrl_reg;
  logic [4:0]   sync1_reg, sync2_reg, sync3_reg, lvl_reg;
  logic [4:0]   rise;
  logic [12:0]  gap_reg;
  logic [31:0]  acc_reg;
  logic [32:0]  acc_sum;
  logic [7:0]   mute_reg;
  logic [1:0]   phase_reg;
  logic [2*W-1:0] adc_reg, aes_reg, spd_reg, opt_reg;
  logic [W-1:0] aes_b_reg;
  logic [W-1:0] hist_l [4];
  logic [W-1:0] hist_r [4];
  logic [2:0]   clk_src, rate;
  logic [1:0]   dac_src, dig_src;
  logic         spdif_sel, paired, paired_active, ext_locked, ref_edge;
  logic         silent, opt_update, ctrl_wr, realign;
  logic [2*W-1:0] dig_smp, dac_smp;

  assign clk_src   = ctrl_reg[dair_pkg::CLK_SRC_LSB +: 3];
  assign dac_src   = ctrl_reg[dair_pkg::DAC_SRC_LSB +: 2];
  assign dig_src   = ctrl_reg[dair_pkg::DIG_SRC_LSB +: 2];
  assign spdif_sel = ctrl_reg[dair_pkg::SPDIF_SEL_BIT];
  assign paired    = ctrl_reg[dair_pkg::PAIRED_BIT];
  assign rate      = ctrl_reg[dair_pkg::RATE_LSB +: 3];
  // Paired link only above 96 kHz; lower rates stay single
  assign paired_active = paired && (rate > dair_pkg::RATE_96K); // R12 R13 R22
  assign ctrl_wr   = psel && penable && pwrite && paddr == dair_pkg::CTRL_OFFSET;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign pready = 1'b1;
  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_reg <= dair_pkg::CTRL_RESET;
    else if (ctrl_wr)
      ctrl_reg <= pwdata & 32'h0000_73F7;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= 1'b0;
      if (paddr == dair_pkg::CTRL_OFFSET)
        prdata <= ctrl_reg;
      else if (paddr == dair_pkg::STATUS_OFFSET)
        prdata <= 32'({rate, 1'b0, mute_reg != 8'h00, paired_active, locked})
                  << dair_pkg::ST_LOCKED_BIT;
      else
      begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Reference pins and lock
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
      lvl_reg   <= 5'h00;
    end
    else
    begin
      sync1_reg <= ref_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // A change counts only once two stages agree
      lvl_reg   <= (sync2_reg & sync3_reg) | (lvl_reg & (sync2_reg | sync3_reg));
    end
  end
  assign rise = sync2_reg & sync3_reg & ~lvl_reg;

  always_comb
  begin
    case (clk_src)
      dair_pkg::CLK_WORD1:   ref_edge = rise[0]; // R9 R18
      dair_pkg::CLK_WORD2:   ref_edge = rise[1]; // R9 R18
      dair_pkg::CLK_AES_SPD: ref_edge = spdif_sel ? rise[3] : rise[2]; // R21 R18
      dair_pkg::CLK_OPTICAL: ref_edge = rise[4]; // R18
      default:               ref_edge = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset || ctrl_wr)
      gap_reg <= TIMEOUT;
    else if (ref_edge)
      gap_reg <= 13'h0000;
    else if (gap_reg != TIMEOUT)
      gap_reg <= gap_reg + 13'h0001;
  end
  assign ext_locked = gap_reg != TIMEOUT;
  assign locked = (clk_src == dair_pkg::CLK_INTERNAL) || ext_locked; // R20 R24
  assign adc_run = locked && mute_reg == 8'h00; // R19
  assign silent = !adc_run; // R25 R16

  // Brief mute after any setting change
  always_ff @(posedge clk)
  begin
    if (reset)
      mute_reg <= SETTLE;
    else if (ctrl_wr)
      mute_reg <= SETTLE; // R16
    else if (mute_reg != 8'h00)
      mute_reg <= mute_reg - 8'h01;
  end

  // ----------------------------------------
  // Word clock generation
  // ----------------------------------------
  assign acc_sum = {1'b0, acc_reg} + {1'b0, dair_pkg::rate_inc(rate)};
  // Phase set on the edge that brings lock, then free-running: a faster
  // multiple reference cannot stall the ticks; drift is not tracked
  assign realign = ref_edge && !ext_locked;
  always_ff @(posedge clk)
  begin
    if (reset)
      acc_reg <= 32'h0000_0000;
    else if (realign)
      acc_reg <= 32'h0000_0000; // R17 R8
    else
      acc_reg <= acc_sum[31:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      word_clk_out <= 4'h0;
      sample_tick  <= 1'b0;
    end
    else
    begin
      word_clk_out <= {4{~acc_reg[31]}}; // R8
      sample_tick  <= acc_sum[32] && !realign;
    end
  end

  // ----------------------------------------
  // Receive capture
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      adc_reg   <= '0;
      aes_reg   <= '0;
      spd_reg   <= '0;
      opt_reg   <= '0;
      aes_b_reg <= '0;
    end
    else
    begin
      if (adc_valid)
        adc_reg <= {adc_left, adc_right}; // R10
      if (aes_a_rx_valid)
        aes_reg <= {aes_a_rx_left, aes_a_rx_right};
      if (aes_b_rx_valid && paired_active)
        aes_b_reg <= aes_b_rx_right; // R2 R3
      // Status bits never reach this block; only samples are taken
      if (spdif_rx_valid)
        spd_reg <= {spdif_rx_left, spdif_rx_right}; // R5
      if (opt_rx_valid)
        opt_reg <= {opt_rx_data[8*W-1 -: W], opt_rx_data[7*W-1 -: W]};
    end
  end

  // Audio of a clock-only input is never picked unless selected
  function automatic logic [2*W-1:0] pick(input logic [1:0] src);
    if (src == dair_pkg::SRC_AES_SPD)
      pick = spdif_sel ? spd_reg : (paired_active ? {aes_reg[2*W-1 -: W], aes_b_reg}
                                                  : aes_reg); // R21 R2
    else if (src == dair_pkg::SRC_OPTICAL)
      pick = opt_reg;
    else
      pick = adc_reg; // R15
  endfunction : pick

  assign dig_smp = silent ? '0 : pick(dig_src); // R6 R7 R25
  assign dac_smp = silent ? '0 : pick(dac_src); // R15 R25

  // ----------------------------------------
  // Transmit
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dac_left       <= '0;
      dac_right      <= '0;
      aes_a_tx_left  <= '0;
      aes_a_tx_right <= '0;
      aes_b_tx_left  <= '0;
      aes_b_tx_right <= '0;
      spdif_tx_left  <= '0;
      spdif_tx_right <= '0;
    end
    else if (sample_tick)
    begin
      dac_left  <= dac_smp[2*W-1 -: W];
      dac_right <= dac_smp[W-1:0];
      if (paired_active)
      begin
        aes_a_tx_left  <= dig_smp[2*W-1 -: W]; // R1
        aes_a_tx_right <= dig_smp[2*W-1 -: W]; // R1
        aes_b_tx_left  <= dig_smp[W-1:0]; // R4
        aes_b_tx_right <= dig_smp[W-1:0]; // R4
      end
      else
      begin
        aes_a_tx_left  <= dig_smp[2*W-1 -: W];
        aes_a_tx_right <= dig_smp[W-1:0];
        aes_b_tx_left  <= dig_smp[2*W-1 -: W]; // R4
        aes_b_tx_right <= dig_smp[W-1:0]; // R4
      end
      // Coax mirrors the primary link in every mode
      spdif_tx_left  <= dig_smp[2*W-1 -: W]; // R23 R11
      spdif_tx_right <= paired_active ? dig_smp[2*W-1 -: W] : dig_smp[W-1:0]; // R23
    end
  end

  // ----------------------------------------
  // Optical sample_interleave
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phase_reg <= 2'h0;
      for (int i = 0; i < 4; i++)
      begin
        hist_l[i] <= '0;
        hist_r[i] <= '0;
      end
    end
    else if (sample_tick)
    begin
      hist_l[0] <= dig_smp[2*W-1 -: W];
      hist_r[0] <= dig_smp[W-1:0];
      for (int i = 1; i < 4; i++)
      begin
        hist_l[i] <= hist_l[i-1];
        hist_r[i] <= hist_r[i-1];
      end
      phase_reg <= opt_update ? 2'h0 : phase_reg + 2'h1;
    end
  end

  always_comb
  begin
    if (rate > dair_pkg::RATE_96K)
      opt_update = sample_tick && phase_reg == 2'h3;
    else if (rate > dair_pkg::RATE_48K)
      opt_update = sample_tick && phase_reg == 2'h1;
    else
      opt_update = sample_tick;
  end

  // History is read before it shifts, so index 0 holds the previous sample and the newest comes from dig_smp
  always_ff @(posedge clk)
  begin
    if (reset)
      opt_tx_data <= '0;
    else if (opt_update)
    begin
      opt_tx_data <= '0;
      if (rate > dair_pkg::RATE_96K)
      begin
        for (int i = 0; i < 4; i++)
        begin
          opt_tx_data[8*W-1-i*W -: W] <= (i == 3) ? dig_smp[2*W-1 -: W] : hist_l[2-i]; // R14
          opt_tx_data[4*W-1-i*W -: W] <= (i == 3) ? dig_smp[W-1:0] : hist_r[2-i]; // R14
        end
      end
      else if (rate > dair_pkg::RATE_48K)
      begin
        opt_tx_data[8*W-1 -: W] <= hist_l[0]; // R14
        opt_tx_data[7*W-1 -: W] <= dig_smp[2*W-1 -: W]; // R14
        opt_tx_data[6*W-1 -: W] <= hist_r[0]; // R14
        opt_tx_data[5*W-1 -: W] <= dig_smp[W-1:0]; // R14
      end
      else
      begin
        opt_tx_data[8*W-1 -: W] <= dig_smp[2*W-1 -: W]; // R10
        opt_tx_data[7*W-1 -: W] <= dig_smp[W-1:0]; // R10
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_internal_locked;
    @(posedge clk) disable iff (reset)
      clk_src == dair_pkg::CLK_INTERNAL |-> locked;
  endproperty
  a_internal_locked: assert property (p_internal_locked) else $error("internal not locked"); // R24

  property p_lock_on_edge;
    @(posedge clk) disable iff (reset)
      ref_edge && !ctrl_wr |=> locked;
  endproperty
  a_lock_on_edge: assert property (p_lock_on_edge) else $error("edge did not lock"); // R20

  property p_no_run_unlocked;
    @(posedge clk) disable iff (reset)
      !locked |-> !adc_run;
  endproperty
  a_no_run_unlocked: assert property (p_no_run_unlocked) else $error("run while unlocked"); // R19

  property p_words_equal;
    @(posedge clk) disable iff (reset)
      word_clk_out == {4{word_clk_out[0]}};
  endproperty
  a_words_equal: assert property (p_words_equal) else $error("word clocks differ"); // R8

  sequence s_single_tick;
    sample_tick && !paired_active;
  endsequence
  property p_b_copies_a;
    @(posedge clk) disable iff (reset)
      s_single_tick |=> aes_b_tx_left == aes_a_tx_left && aes_b_tx_right == aes_a_tx_right;
  endproperty
  a_b_copies_a: assert property (p_b_copies_a) else $error("secondary not a copy"); // R4

  property p_spdif_mirror;
    @(posedge clk) disable iff (reset)
      $rose(sample_tick) |=> spdif_tx_left == aes_a_tx_left;
  endproperty
  a_spdif_mirror: assert property (p_spdif_mirror) else $error("coax not mirrored"); // R23

  property p_silent_unlocked;
    @(posedge clk) disable iff (reset)
      sample_tick && !locked |=> aes_a_tx_left == '0 && dac_left == '0;
  endproperty
  a_silent_unlocked: assert property (p_silent_unlocked) else $error("audio while unlocked"); // R25

  property p_mute_after_write;
    @(posedge clk) disable iff (reset)
      psel && penable && pwrite && paddr == dair_pkg::CTRL_OFFSET |=> !adc_run [*8];
  endproperty
  a_mute_after_write: assert property (p_mute_after_write) else $error("no mute on change"); // R16

  property p_low_rate_single;
    @(posedge clk) disable iff (reset)
      rate <= dair_pkg::RATE_96K |-> !paired_active;
  endproperty
  a_low_rate_single: assert property (p_low_rate_single) else $error("paired at low rate"); // R12
endmodule : dair_router
`default_nettype wire

/* File: common/dair_pkg.sv */
package dair_pkg;
  // Register map
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  // Control fields
  localparam int CLK_SRC_LSB = 0;
  localparam int DAC_SRC_LSB = 4;
  localparam int DIG_SRC_LSB = 6;
  localparam int SPDIF_SEL_BIT = 8;
  localparam int PAIRED_BIT  = 9;
  localparam int RATE_LSB    = 12;
  // Status fields
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_PAIRED_BIT = 1;
  localparam int ST_MUTED_BIT  = 2;
  localparam int ST_RATE_LSB   = 4;
  // Timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int LOCK_TIMEOUT_US = 100;
  localparam int LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE_US       = 1;
  localparam int SETTLE_CYC      = SETTLE_US * (CLK_HZ / 1_000_000);

  typedef enum logic [2:0] {
    CLK_INTERNAL = 3'h0,
    CLK_WORD1    = 3'h1,
    CLK_WORD2    = 3'h2,
    CLK_AES_SPD  = 3'h3,
    CLK_OPTICAL  = 3'h4
  } dair_clk_src_type;

  typedef enum logic [1:0] {
    SRC_ADC     = 2'h0,
    SRC_AES_SPD = 2'h1,
    SRC_OPTICAL = 2'h2
  } dair_src_type;

  typedef enum logic [2:0] {
    RATE_44K1  = 3'h0,
    RATE_48K   = 3'h1,
    RATE_88K2  = 3'h2,
    RATE_96K   = 3'h3,
    RATE_176K4 = 3'h4,
    RATE_192K  = 3'h5
  } dair_rate_type;

  // Phase increment of the word clock accumulator for each rate
  function automatic logic [31:0] rate_inc(input logic [2:0] rate);
    longint fs;
    case (rate)
      3'h0: fs = 44100;
      3'h1: fs = 48000;
      3'h2: fs = 88200;
      3'h3: fs = 96000;
      3'h4: fs = 176400;
      default: fs = 192000;
    endcase
    return 32'((fs << 32) / longint'(CLK_HZ));
  endfunction : rate_inc
endpackage : dair_pkg

/* File: verif/dair_ext_clk.sv */
`timescale 1ns/1ps
`default_nettype none
module dair_ext_clk (
  // Per-pin enables
  input  wire logic [4:0] ref_en,
  // Reference pins
  output logic      [4:0] ref_pin
);
  logic link_clk;

  // ----------------------------------------
  // Link clock, phase unrelated to clk
  // ----------------------------------------
  initial
  begin
    link_clk = 1'b0;
    #37;
    forever #100 link_clk = ~link_clk;
  end

  // Silent pins sit low so no stale edge survives
  assign ref_pin = ref_en & {5{link_clk}};
endmodule : dair_ext_clk
`default_nettype wire

/* File: verif/dair_router_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dair_router_tb;
  localparam int W = 24;
  localparam logic [W-1:0] ADL = 24'h1A2B3C, ADR = 24'h4D5E6F, AL = 24'h111111;
  localparam logic [W-1:0] AR = 24'h222222, BR = 24'h333333, SL = 24'h444444;
  localparam logic [W-1:0] SR = 24'h555555, O1 = 24'h666666, O2 = 24'h777777;
  logic           clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd;
  logic [4:0]     ref_pin, ref_en;
  logic           aes_a_rx_valid, aes_b_rx_valid, spdif_rx_valid, opt_rx_valid, adc_valid;
  logic [W-1:0]   aes_a_rx_left, aes_a_rx_right, aes_b_rx_right, spdif_rx_left;
  logic [W-1:0]   spdif_rx_right, adc_left, adc_right, dac_left, dac_right;
  logic [W-1:0]   aes_a_tx_left, aes_a_tx_right, aes_b_tx_left, aes_b_tx_right;
  logic [W-1:0]   spdif_tx_left, spdif_tx_right;
  logic [8*W-1:0] opt_rx_data, opt_tx_data;
  logic [3:0]     word_clk_out;
  logic           adc_run, sample_tick, locked, ok;
  int             n_mismatch, n_checks, cyc;

  dair_router #(.W(W)) i_dut (.clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .ref_pin, .aes_a_rx_valid, .aes_a_rx_left,
    .aes_a_rx_right, .aes_b_rx_valid, .aes_b_rx_right, .spdif_rx_valid, .spdif_rx_left,
    .spdif_rx_right, .opt_rx_valid, .opt_rx_data, .adc_valid, .adc_left, .adc_right,
    .adc_run, .dac_left, .dac_right, .sample_tick, .aes_a_tx_left, .aes_a_tx_right,
    .aes_b_tx_left, .aes_b_tx_right, .spdif_tx_left, .spdif_tx_right, .opt_tx_data,
    .word_clk_out, .locked);
  dair_ext_clk i_ext (.ref_en(ref_en), .ref_pin(ref_pin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] cw(input logic [2:0] cs, input logic [1:0] da, dg,
                                     input logic sp, pr, input logic [2:0] rt);
    return {17'h0, rt, 2'h0, pr, sp, dg, da, 1'b0, cs};
  endfunction : cw

  task automatic wr_ctrl(input logic [31:0] v);
    apb(1'b1, dair_pkg::CTRL_OFFSET, v);
    @(posedge clk);
    #1;
    chk(32'(adc_run), 32'h0);
    repeat (50) @(posedge clk);
  endtask : wr_ctrl

  // Outputs load on the edge after a tick
  task automatic tick(input int n);
    repeat (n)
    begin
      do @(negedge clk); while (sample_tick !== 1'b1);
    end
    @(posedge clk);
    #1;
  endtask : tick

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(1'b0, dair_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, dair_pkg::CTRL_RESET);
    apb(1'b0, dair_pkg::STATUS_OFFSET, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, dair_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, dair_pkg::STATUS_OFFSET, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, dair_pkg::CTRL_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, dair_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_73F7);
    wr_ctrl(32'h0);
  endtask : t_regs

  task automatic t_single;
    logic [1:0]   dg[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    logic         sp[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [W-1:0] el[4] = '{ADL, AL, SL, O1};
    logic [W-1:0] er_[4] = '{ADR, AR, SR, O2};
    for (int i = 0; i < 4; i++)
    begin
      wr_ctrl(cw(3'h0, dg[i], dg[i], sp[i], 1'b1, 3'h0));
      tick(2);
      chk(32'(aes_a_tx_left), 32'(el[i]));
      chk(32'(aes_a_tx_right), 32'(er_[i]));
      chk(32'(aes_b_tx_left), 32'(el[i]));
      chk(32'(aes_b_tx_right), 32'(er_[i]));
      chk(32'(spdif_tx_left), 32'(el[i]));
      chk(32'(spdif_tx_right), 32'(er_[i]));
      chk(32'(dac_left), 32'(el[i]));
      chk(32'(dac_right), 32'(er_[i]));
      chk(32'(opt_tx_data[191:168]), 32'(el[i]));
      chk(32'(opt_tx_data[167:144]), 32'(er_[i]));
    end
  endtask : t_single

  task automatic t_paired;
    wr_ctrl(cw(3'h0, 2'h1, 2'h1, 1'b0, 1'b1, 3'h5));
    tick(8);
    chk(32'(aes_a_tx_left), 32'(AL));
    chk(32'(aes_a_tx_right), 32'(AL));
    chk(32'(aes_b_tx_left), 32'(BR));
    chk(32'(aes_b_tx_right), 32'(BR));
    chk(32'(spdif_tx_right), 32'(AL));
    chk(32'(dac_right), 32'(BR));
    for (int k = 0; k < 4; k++)
    begin
      chk(32'(opt_tx_data[191-24*k -: 24]), 32'(AL));
      chk(32'(opt_tx_data[95-24*k -: 24]), 32'(BR));
    end
    wr_ctrl(cw(3'h0, 2'h1, 2'h1, 1'b0, 1'b1, 3'h3));
    tick(4);
    chk(32'(aes_b_tx_right), 32'(AR));
    chk(32'(opt_tx_data[167:144]), 32'(AL));
    chk(32'(opt_tx_data[143:120]), 32'(AR));
  endtask : t_paired

  task automatic t_lock;
    logic [2:0] cs[5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4};
    logic       sp[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      ref_en <= ~(5'h01 << i);
      wr_ctrl(cw(cs[i], 2'h0, 2'h0, sp[i], 1'b0, 3'h1));
      repeat (200) @(posedge clk);
      #1;
      chk(32'(locked), 32'h0);
      tick(1);
      chk(32'(aes_a_tx_left), 32'h0);
      ref_en <= 5'h1F;
      repeat (100) @(posedge clk);
      #1;
      chk(32'(locked), 32'h1);
      tick(2);
      chk(32'(aes_a_tx_left), 32'(ADL));
      ok = 1'b1;
      repeat (200)
      begin
        @(negedge clk);
        ok &= (word_clk_out == 4'h0 || word_clk_out == 4'hF);
      end
      chk(32'(ok), 32'h1);
    end
    ref_en <= 5'h00;
    repeat (3000) @(posedge clk);
    #1;
    chk(32'(locked), 32'h1);
    repeat (1300) @(posedge clk);
    #1;
    chk(32'(locked), 32'h0);
    chk(32'(adc_run), 32'h0);
    tick(1);
    chk(32'(aes_a_tx_left | opt_tx_data[191:168]), 32'h0);
    apb(1'b1, dair_pkg::CTRL_OFFSET, 32'h0);
    @(posedge clk);
    #1;
    chk(32'(locked), 32'h1);
  endtask : t_lock

  // ----------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      $display("[ERR] %0t run exceeded cycle limit", $time);
      summarize();
    end
  end

  initial
  begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; ref_en = 5'h00;
    {aes_a_rx_valid, aes_b_rx_valid, spdif_rx_valid, opt_rx_valid, adc_valid} = 5'h1F;
    aes_a_rx_left = AL; aes_a_rx_right = AR; aes_b_rx_right = BR;
    spdif_rx_left = SL; spdif_rx_right = SR; adc_left = ADL; adc_right = ADR;
    opt_rx_data = {O1, O2, {6{24'h8A5A5A}}};
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(adc_run), 32'h0);
    repeat (45) @(posedge clk);
    #1;
    chk(32'(adc_run), 32'h1);
    t_regs();
    t_single();
    t_paired();
    t_lock();
    summarize();
  end
endmodule : dair_router_tb
`default_nettype wire
